// *** rtc_bcd_pair.sv ***
// Two-digit BCD counter with software load and carry out at its wrap value.
`default_nettype none

module rtc_bcd_pair #(
  parameter logic [7:0] MAX = 8'h59
) (
  // Clock and reset.
  input  wire logic       clk_sys,
  input  wire logic       reset,
  // Count and load controls.
  input  wire logic       inc,
  input  wire logic       load,
  input  wire logic [7:0] load_val,
  // Counter value and carry.
  output logic [7:0]      value,
  output logic            wrap
);

  logic [7:0] val_q;
  logic [7:0] val_d;

  // A load wins over a count in the same cycle.
  always_comb begin
    val_d = val_q;
    if (load) begin
      val_d = load_val;
    end else if (inc) begin
      if (val_q == MAX) begin
        val_d = rtc_pkg::RST_PAIR;
      end else if (val_q[3:0] == 4'h9) begin
        val_d = {val_q[7:4] + 4'h1, 4'h0};
      end else begin
        val_d = {val_q[7:4], val_q[3:0] + 4'h1};
      end
    end
  end

  // Registers the counter.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      val_q <= rtc_pkg::RST_PAIR;
    end else begin
      val_q <= val_d;
    end
  end

  assign value = val_q;
  assign wrap  = inc & ~load & (val_q == MAX);

endmodule : rtc_bcd_pair

`default_nettype wire

// *** rtc_pkg.sv ***
// Constants, field layouts and bus carrier type for the BCD time and alarm value block.
// Contract
// - weekday digit bits 10-8, values 0-6
// - hour tens bits 5-4, values 0-2
// - hour ones bits 3-0, values 0-9
// - minute tens bits 14-12, values 0-5
// - minute ones bits 11-8, values 0-9
// - second tens bits 6-4, values 0-5
// - second ones bits 3-0, values 0-9
// - alarm month tens single bit 12
// - alarm month ones bits 11-8, 0-9
// - alarm day tens bits 5-4, 0-3
// - alarm day ones bits 3-0, 0-9
// - gated views writable only when write enable set
// - unused view bits read as zero
// - time pointer 01 weekday/hours, 00 minutes/seconds
// - alarm pointer 10 month/day, 01, 00 views
// - pointer decrements on upper access, stops 00
// - lower minutes/seconds write clears half-second status
// - time values locked while write enable clear
`default_nettype none

package rtc_pkg;

  // Register word addresses on the plain register port.
  localparam logic [1:0] ADDR_CONFIG    = 2'h0;
  localparam logic [1:0] ADDR_ALARM_CFG = 2'h1;
  localparam logic [1:0] ADDR_TIME_WIN  = 2'h2;
  localparam logic [1:0] ADDR_ALARM_WIN = 2'h3;

  // Field positions inside the configuration words.
  localparam int WREN_BIT = 13;
  localparam int HALF_BIT = 11;
  localparam int PTR_LSB  = 8;

  // Window pointer codes.
  localparam logic [1:0] PTR_MINUTES_SECONDS_VIEW = 2'h0;
  localparam logic [1:0] PTR_WKHR   = 2'h1;
  localparam logic [1:0] PTR_MONDAY = 2'h2;

  // Implemented bits of each view; all others read as zero.
  localparam logic [15:0] MASK_WKHR   = 16'h073f;
  localparam logic [15:0] MASK_MINUTES_SECONDS_VIEW = 16'h7f7f;
  localparam logic [15:0] MASK_MONDAY = 16'h1f3f;

  // Wrap values of the BCD counters.
  localparam logic [7:0] MAX_SEC  = 8'h59;
  localparam logic [7:0] MAX_MIN  = 8'h59;
  localparam logic [7:0] MAX_HOUR = 8'h23;
  localparam logic [2:0] MAX_WEEKDAY_DIGIT = 3'h6;

  // Values after reset.
  localparam logic [15:0] RST_VIEW = 16'h0000;
  localparam logic [7:0]  RST_PAIR = 8'h00;
  localparam logic [1:0]  RST_PTR  = 2'h0;

  // Half-second timing at the system clock rate.
  localparam int CLK_PERIOD_NS   = 4;
  localparam int HALF_SEC_NS     = 500_000_000;
  localparam int HALF_SEC_CYCLES = HALF_SEC_NS / CLK_PERIOD_NS;

  // One register port request.
  typedef struct packed {
    logic [1:0]  addr;
    logic [15:0] wdata;
    logic [1:0]  be;
    logic        wr;
    logic        rd;
  } reg_req_t;

endpackage : rtc_pkg

`default_nettype wire

// *** rtc_tick_div.sv ***
// Divider that makes the one-cycle half-second enable pulse.
`default_nettype none

module rtc_tick_div #(
  parameter int CYCLES = 125_000_000
) (
  // Clock and reset.
  input  wire logic clk_sys,
  input  wire logic reset,
  // Restart the period from zero.
  input  wire logic restart,
  // Half-second enable pulse.
  output logic      tick
);

  localparam int CW = $clog2(CYCLES);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          tick_q;
  logic          tick_d;

  // Counts system cycles; the pulse is set on the last one of each period and shows on tick one cycle later.
  always_comb begin
    tick_d = 1'b0;
    cnt_d  = cnt_q + 1'b1;
    if (restart) begin
      cnt_d = '0;
    end else if (cnt_q == CW'(CYCLES - 1)) begin
      cnt_d  = '0;
      tick_d = 1'b1;
    end
  end

  // Registers the divider state.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

endmodule : rtc_tick_div

`default_nettype wire

// *** rtc_value_regs.sv ***
// Windowed BCD time and alarm value registers with a running time-of-day counter.
//
// The implementer's own choices: the address map and strobed register access.
`default_nettype none

module rtc_value_regs #(
  parameter int HALF_SEC_CYCLES = rtc_pkg::HALF_SEC_CYCLES
) (
  // Clock and reset.
  input  wire logic              clk_sys,
  input  wire logic              reset,
  // Register port.
  input  wire rtc_pkg::reg_req_t req,
  output logic [15:0]            rd_data
);

  // Time counters.
  logic [7:0] sec_v;
  logic [7:0] min_v;
  logic [7:0] hour_v;
  logic       sec_wrap;
  logic       min_wrap;
  logic       hour_wrap;
  logic       tick;

  // Control and alarm state.
  logic        wren_q;
  logic        wren_d;
  logic        half_q;
  logic        half_d;
  logic [1:0]  tptr_q;
  logic [1:0]  tptr_d;
  logic [1:0]  aptr_q;
  logic [1:0]  aptr_d;
  logic [2:0]  weekday_digit_q;
  logic [2:0]  weekday_digit_d;
  logic [15:0] al_md_q;
  logic [15:0] al_md_d;
  logic [15:0] al_wh_q;
  logic [15:0] al_wh_d;
  logic [15:0] al_ms_q;
  logic [15:0] al_ms_d;
  logic [15:0] rd_q;
  logic [15:0] rd_d;

  // Decoded accesses.
  logic       t_acc;
  logic       a_acc;
  logic       t_wr_hi;
  logic       t_wr_lo;
  logic       a_wr;
  logic       sec_load;
  logic       min_load;
  logic       hour_load;
  logic       weekday_digit_load;
  logic       sec_inc;
  logic [15:0] time_view;
  logic [15:0] alarm_view;

  // Decrements a window pointer down to zero and holds it there.
  function automatic logic [1:0] ptr_step(input logic [1:0] p);
    ptr_step = (p == rtc_pkg::PTR_MINUTES_SECONDS_VIEW) ? p : p - 2'h1;
  endfunction : ptr_step

  // Half-second pulse source; restarted when software sets the seconds.
  rtc_tick_div #(
    .CYCLES (HALF_SEC_CYCLES)
  ) u_div (
    .clk_sys (clk_sys),
    .reset   (reset),
    .restart (sec_load),
    .tick    (tick)
  );

  // Seconds, minutes and hours in BCD with carries between them.
  rtc_bcd_pair #(.MAX (rtc_pkg::MAX_SEC)) u_sec (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .inc      (sec_inc),
    .load     (sec_load),
    .load_val ({1'b0, req.wdata[6:0]}),
    .value    (sec_v),
    .wrap     (sec_wrap)
  );

  rtc_bcd_pair #(.MAX (rtc_pkg::MAX_MIN)) u_min (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .inc      (sec_wrap),
    .load     (min_load),
    .load_val ({1'b0, req.wdata[14:8]}),
    .value    (min_v),
    .wrap     (min_wrap)
  );

  rtc_bcd_pair #(.MAX (rtc_pkg::MAX_HOUR)) u_hour (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .inc      (min_wrap),
    .load     (hour_load),
    .load_val ({2'h0, req.wdata[5:0]}),
    .value    (hour_v),
    .wrap     (hour_wrap)
  );

  // Access decode and the write gating by the write enable bit.
  always_comb begin
    t_acc     = (req.addr == rtc_pkg::ADDR_TIME_WIN) & ((req.wr & req.be[1]) | req.rd);
    a_acc     = (req.addr == rtc_pkg::ADDR_ALARM_WIN) & ((req.wr & req.be[1]) | req.rd);
    t_wr_hi   = req.wr & (req.addr == rtc_pkg::ADDR_TIME_WIN) & wren_q & req.be[1];
    t_wr_lo   = req.wr & (req.addr == rtc_pkg::ADDR_TIME_WIN) & wren_q & req.be[0];
    a_wr      = req.wr & (req.addr == rtc_pkg::ADDR_ALARM_WIN);
    sec_load  = t_wr_lo & (tptr_q == rtc_pkg::PTR_MINUTES_SECONDS_VIEW);
    min_load  = t_wr_hi & (tptr_q == rtc_pkg::PTR_MINUTES_SECONDS_VIEW);
    hour_load = t_wr_lo & (tptr_q == rtc_pkg::PTR_WKHR);
    weekday_digit_load = t_wr_hi & (tptr_q == rtc_pkg::PTR_WKHR);
    sec_inc   = tick & half_q;
  end

  // Views presented through the two windows.
  always_comb begin
    time_view = rtc_pkg::RST_VIEW;
    if (tptr_q == rtc_pkg::PTR_WKHR) begin
      time_view = {5'h0, weekday_digit_q, hour_v} & rtc_pkg::MASK_WKHR;
    end else if (tptr_q == rtc_pkg::PTR_MINUTES_SECONDS_VIEW) begin
      time_view = {min_v, sec_v} & rtc_pkg::MASK_MINUTES_SECONDS_VIEW;
    end
    alarm_view = rtc_pkg::RST_VIEW;
    if (aptr_q == rtc_pkg::PTR_MONDAY) begin
      alarm_view = al_md_q;
    end else if (aptr_q == rtc_pkg::PTR_WKHR) begin
      alarm_view = al_wh_q;
    end else if (aptr_q == rtc_pkg::PTR_MINUTES_SECONDS_VIEW) begin
      alarm_view = al_ms_q;
    end
  end

  // Next values of the control, alarm and read-data registers.
  always_comb begin
    wren_d  = wren_q;
    half_d  = half_q;
    tptr_d  = tptr_q;
    aptr_d  = aptr_q;
    weekday_digit_d  = weekday_digit_q;
    al_md_d = al_md_q;
    al_wh_d = al_wh_q;
    al_ms_d = al_ms_q;
    rd_d    = rtc_pkg::RST_VIEW;
    if (tick) begin
      half_d = ~half_q;
    end
    if (sec_load) begin
      half_d = 1'b0;
    end
    if (weekday_digit_load) begin
      weekday_digit_d = req.wdata[10:8];
    end else if (hour_wrap) begin
      weekday_digit_d = (weekday_digit_q == rtc_pkg::MAX_WEEKDAY_DIGIT) ? 3'h0 : weekday_digit_q + 3'h1;
    end
    if (t_acc) begin
      tptr_d = ptr_step(tptr_q);
    end
    if (a_acc) begin
      aptr_d = ptr_step(aptr_q);
    end
    if (req.wr && req.addr == rtc_pkg::ADDR_CONFIG) begin
      if (req.be[1]) begin
        wren_d = req.wdata[rtc_pkg::WREN_BIT];
        tptr_d = req.wdata[rtc_pkg::PTR_LSB +: 2];
      end
    end else if (req.wr && req.addr == rtc_pkg::ADDR_ALARM_CFG) begin
      if (req.be[1]) begin
        aptr_d = req.wdata[rtc_pkg::PTR_LSB +: 2];
      end
    end
    if (a_wr && aptr_q == rtc_pkg::PTR_MONDAY && wren_q) begin
      if (req.be[1]) al_md_d[15:8] = req.wdata[15:8] & rtc_pkg::MASK_MONDAY[15:8];
      if (req.be[0]) al_md_d[7:0] = req.wdata[7:0] & rtc_pkg::MASK_MONDAY[7:0];
    end else if (a_wr && aptr_q == rtc_pkg::PTR_WKHR && wren_q) begin
      if (req.be[1]) al_wh_d[15:8] = req.wdata[15:8] & rtc_pkg::MASK_WKHR[15:8];
      if (req.be[0]) al_wh_d[7:0] = req.wdata[7:0] & rtc_pkg::MASK_WKHR[7:0];
    end else if (a_wr && aptr_q == rtc_pkg::PTR_MINUTES_SECONDS_VIEW) begin
      if (req.be[1]) al_ms_d[15:8] = req.wdata[15:8] & rtc_pkg::MASK_MINUTES_SECONDS_VIEW[15:8];
      if (req.be[0]) al_ms_d[7:0] = req.wdata[7:0] & rtc_pkg::MASK_MINUTES_SECONDS_VIEW[7:0];
    end
    if (req.rd) begin
      if (req.addr == rtc_pkg::ADDR_CONFIG) begin
        rd_d = {2'h0, wren_q, 1'b0, half_q, 1'b0, tptr_q, 8'h00};
      end else if (req.addr == rtc_pkg::ADDR_ALARM_CFG) begin
        rd_d = {6'h00, aptr_q, 8'h00};
      end else if (req.addr == rtc_pkg::ADDR_TIME_WIN) begin
        rd_d = time_view;
      end else begin
        rd_d = alarm_view;
      end
    end
  end

  // Registers the control, alarm and read-data state.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wren_q  <= 1'b0;
      half_q  <= 1'b0;
      tptr_q  <= rtc_pkg::RST_PTR;
      aptr_q  <= rtc_pkg::RST_PTR;
      weekday_digit_q  <= 3'h0;
      al_md_q <= rtc_pkg::RST_VIEW;
      al_wh_q <= rtc_pkg::RST_VIEW;
      al_ms_q <= rtc_pkg::RST_VIEW;
      rd_q    <= rtc_pkg::RST_VIEW;
    end else begin
      wren_q  <= wren_d;
      half_q  <= half_d;
      tptr_q  <= tptr_d;
      aptr_q  <= aptr_d;
      weekday_digit_q  <= weekday_digit_d;
      al_md_q <= al_md_d;
      al_wh_q <= al_wh_d;
      al_ms_q <= al_ms_d;
      rd_q    <= rd_d;
    end
  end

  assign rd_data = rd_q;

  // Checks on the block's own behaviour.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence time_wkhr_read;
    req.rd && req.addr == rtc_pkg::ADDR_TIME_WIN && tptr_q == rtc_pkg::PTR_WKHR;
  endsequence

  sequence alarm_md_read;
    req.rd && req.addr == rtc_pkg::ADDR_ALARM_WIN && aptr_q == rtc_pkg::PTR_MONDAY;
  endsequence

  wkhr_read_a: assert property (time_wkhr_read |=>
    rd_q == ({5'h0, $past(weekday_digit_q), $past(hour_v)} & rtc_pkg::MASK_WKHR)
    && tptr_q == rtc_pkg::PTR_MINUTES_SECONDS_VIEW)
    else $error("Weekday/hours read returned the wrong view.");

  unused_zero_a: assert property (time_wkhr_read |=> (rd_q & ~rtc_pkg::MASK_WKHR) == 16'h0000)
    else $error("Unused weekday/hours bits read as non-zero.");

  alarm_md_a: assert property (alarm_md_read |=> rd_q == $past(al_md_q)
    && (rd_q & ~rtc_pkg::MASK_MONDAY) == 16'h0000)
    else $error("Alarm month/day read returned the wrong view.");

  ptr_dec_a: assert property (t_acc && tptr_q != rtc_pkg::PTR_MINUTES_SECONDS_VIEW
    && !(req.wr && req.addr == rtc_pkg::ADDR_CONFIG) |=> tptr_q == $past(tptr_q) - 2'h1)
    else $error("Time window pointer did not step down.");

  ptr_stop_a: assert property (a_acc && aptr_q == rtc_pkg::PTR_MINUTES_SECONDS_VIEW |=>
    aptr_q == rtc_pkg::PTR_MINUTES_SECONDS_VIEW)
    else $error("Alarm window pointer moved below zero.");

  lock_a: assert property (req.wr && req.addr == rtc_pkg::ADDR_TIME_WIN && !wren_q
    |=> (sec_v == $past(sec_v) || $past(sec_inc)) && (hour_v == $past(hour_v) || $past(min_wrap)))
    else $error("Locked time value changed by a write.");

  gate_alarm_a: assert property (a_wr && !wren_q && aptr_q == rtc_pkg::PTR_WKHR
    |=> al_wh_q == $past(al_wh_q))
    else $error("Alarm weekday/hours written while locked.");

  half_clr_a: assert property (sec_load |=> !half_q ##1 !half_q)
    else $error("Half-second status not cleared by a seconds write.");

  sec_carry_a: assert property (sec_inc && sec_v == rtc_pkg::MAX_SEC && !sec_load && !min_load
    && min_v != rtc_pkg::MAX_MIN |=> sec_v == 8'h00 && min_v != $past(min_v))
    else $error("Seconds wrap did not carry into minutes.");

  weekday_digit_wrap_a: assert property (hour_wrap && !weekday_digit_load && weekday_digit_q == rtc_pkg::MAX_WEEKDAY_DIGIT
    |=> weekday_digit_q == 3'h0)
    else $error("Weekday did not wrap after six.");

  rd_idle_a: assert property (!req.rd |=> rd_q == 16'h0000)
    else $error("Read data not zero after an idle cycle.");

  // A minutes/seconds read shows both counters in their own fields.
  sequence time_ms_read;
    req.rd && req.addr == rtc_pkg::ADDR_TIME_WIN && tptr_q == rtc_pkg::PTR_MINUTES_SECONDS_VIEW;
  endsequence

  minutes_seconds_view_read_a: assert property (time_ms_read |=>
    {1'b0, rd_q[14:8]} == $past(min_v) && {1'b0, rd_q[6:0]} == $past(sec_v)
    && !rd_q[15] && !rd_q[7])
    else $error("Minutes/seconds read returned the wrong view.");

  time_rsv_a: assert property (req.rd && tptr_q[1]
    && req.addr == rtc_pkg::ADDR_TIME_WIN |=> rd_q == 16'h0000)
    else $error("Unused time window view did not read as zero.");

  md_lock_a: assert property (a_wr && !wren_q && aptr_q == rtc_pkg::PTR_MONDAY
    |=> al_md_q == $past(al_md_q))
    else $error("Alarm month/day written while locked.");

  hour_wrap_a: assert property (min_wrap && !hour_load && hour_v == rtc_pkg::MAX_HOUR
    |=> hour_v == 8'h00)
    else $error("Hours did not wrap after twenty-three.");

  half_tog_a: assert property (tick && !sec_load |=> half_q != $past(half_q))
    else $error("Half-second status did not toggle on a tick.");

endmodule : rtc_value_regs

`default_nettype wire

// *** rtc_value_regs_tb.sv ***
// Self-checking testbench for the windowed BCD time and alarm value registers.
`default_nettype none

module rtc_value_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;

  // Short half-second period so that counting is seen in a few hundred cycles.
  localparam int HALF = 100;

  logic              clk_sys;
  logic              reset;
  rtc_pkg::reg_req_t req;
  logic [15:0]       rd_data;
  int                err_total;
  int                compares;

  // Device under test.
  rtc_value_regs #(
    .HALF_SEC_CYCLES(HALF)
  ) rtc_value_regs_i (
    .clk_sys(clk_sys),
    .reset  (reset),
    .req    (req),
    .rd_data(rd_data)
  );

  // Clock of 4 ns period.
  always #2 clk_sys = ~clk_sys;

  // Compares one value and reports a mismatch at once.
  task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // One-cycle write strobe with address, data and byte enables.
  task automatic wr(input logic [1:0] a, input logic [15:0] d, input logic [1:0] be = 2'h3);
    @(posedge clk_sys);
    req.addr  <= a;
    req.wdata <= d;
    req.be    <= be;
    req.wr    <= 1'b1;
    @(posedge clk_sys);
    req.wr    <= 1'b0;
  endtask : wr

  // One-cycle read strobe; data are taken in the cycle after it.
  task automatic rd_chk(input logic [1:0] a, input logic [15:0] exp, input string what);
    @(posedge clk_sys);
    req.addr <= a;
    req.rd   <= 1'b1;
    @(posedge clk_sys);
    req.rd   <= 1'b0;
    #1;
    check(what, rd_data, exp);
  endtask : rd_chk

  // Writes while locked are dropped, except to the alarm minutes/seconds view, but the pointer still steps down.
  task automatic lock_test;
    rd_chk(2'h0, 16'h0000, "config after reset");
    wr(2'h0, 16'h0100);
    wr(2'h2, 16'h0312);
    rd_chk(2'h0, 16'h0000, "time pointer after refused write");
    wr(2'h2, 16'h1234);
    rd_chk(2'h2, 16'h0000, "locked minutes_seconds_view");
    wr(2'h0, 16'h0200);
    rd_chk(2'h2, 16'h0000, "time reserved view");
    wr(2'h0, 16'h0100);
    rd_chk(2'h2, 16'h0000, "locked weekday hours");
    wr(2'h1, 16'h0200);
    wr(2'h3, 16'h1231);
    wr(2'h3, 16'h0623);
    wr(2'h3, 16'h5958);
    wr(2'h1, 16'h0200);
    rd_chk(2'h3, 16'h0000, "locked alarm month day");
    rd_chk(2'h3, 16'h0000, "locked alarm weekday hours");
    rd_chk(2'h3, 16'h5958, "ungated alarm minutes_seconds_view");
  endtask : lock_test

  // Field placement, unused bits and pointer walk of the alarm window.
  task automatic alarm_test;
    wr(2'h0, 16'h2000);
    wr(2'h1, 16'h0200);
    wr(2'h3, 16'h1231);
    wr(2'h3, 16'h0623);
    wr(2'h3, 16'h4837);
    wr(2'h3, 16'h4837);
    wr(2'h1, 16'h0200);
    rd_chk(2'h3, 16'h1231, "alarm month day");
    rd_chk(2'h3, 16'h0623, "alarm weekday hours");
    rd_chk(2'h3, 16'h4837, "alarm minutes_seconds_view");
    rd_chk(2'h1, 16'h0000, "alarm pointer stops");
    wr(2'h1, 16'h0200);
    repeat (3) wr(2'h3, 16'hffff);
    wr(2'h1, 16'h0300);
    rd_chk(2'h3, 16'h0000, "alarm reserved view");
    rd_chk(2'h3, 16'h1f3f, "alarm month day unused");
    rd_chk(2'h3, 16'h073f, "alarm weekday hours unused");
    rd_chk(2'h3, 16'h7f7f, "alarm minutes_seconds_view unused");
    wr(2'h1, 16'h0100);
    wr(2'h3, 16'h0000, 2'h1);
    rd_chk(2'h1, 16'h0100, "pointer after lower write");
  endtask : alarm_test

  // Full carry chain from seconds to weekday and the half-second status.
  task automatic time_test;
    wr(2'h0, 16'h2100);
    wr(2'h2, 16'h0623);
    wr(2'h2, 16'h5959);
    repeat (150) @(posedge clk_sys);
    rd_chk(2'h0, 16'h2800, "half second set");
    repeat (95) @(posedge clk_sys);
    rd_chk(2'h2, 16'h0000, "minutes_seconds_view wrapped");
    wr(2'h0, 16'h2100);
    rd_chk(2'h2, 16'h0000, "weekday hours wrapped");
    wr(2'h2, 16'h0000, 2'h1);
    repeat (150) @(posedge clk_sys);
    rd_chk(2'h0, 16'h2800, "half second again");
    wr(2'h2, 16'h0000, 2'h1);
    rd_chk(2'h0, 16'h2000, "half second cleared");
  endtask : time_test

  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict;
    $display("Comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict

  // Main sequence: reset for ten cycles, then the scenarios in turn.
  initial begin
    clk_sys   = 1'b0;
    reset     = 1'b1;
    req       = '0;
    err_total = 0;
    compares  = 0;
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    lock_test();
    alarm_test();
    time_test();
    print_verdict();
  end

  // Watchdog well beyond the expected run of about five hundred cycles.
  initial begin
    #80000;
    err_total++;
    print_verdict();
  end

endmodule : rtc_value_regs_tb

`default_nettype wire
